// File: rtl/cmc_checker.v
// Contract
// - Config frames checked by 16-bit CRC
// - User mode recomputes 32-bit frame CRC
// - Checking runs until reconfiguration request
// - Zero signature drives fault flag low
// - Nonzero signature raises flag, starts search
// - Detect all one to five bit errors
// - Report type and location for single/double
// - Code 017 selects report scan path
// - Low four report bits hold type
// - Continue to next frame after error
// - Generator uses 32-bit ANSI polynomial
// - Reference signature stored per frame
// - Skipped regions keep last flag status
// - Scrubbing corrects single and double errors
// - Code 015 selects 47-bit insertion path
// - Insertion honoured only in user mode
// - Insertion flips bits, enters test mode
// - Inject first frame only; report readable
// - Report register is 67 bits wide
// - Update registers copy report next cycle; the JTAG copy here waits while the report path is shifting
// - Insertion update loads internal register
//
// Our own choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "cmc_map.vh"

module cmc_checker #(
  // Nominal data bits per frame, ahead of the 32 reference bits.
  parameter FRAME_BITS = 64,
  // Bit position width; it must cover the data and reference bits of a frame.
  parameter LOC_W      = 11
) (
  // Clock, enable and reset.
  input  wire        aclk,
  input  wire        aclk_en,
  input  wire        aresetn,
  input  wire        reconfig_request_n,
  // Configuration cell memory stream, one bit per cycle.
  input  wire        cfg_mode,
  input  wire        cell_valid,
  input  wire        cell_bit,
  input  wire        cell_skip,
  input  wire        cell_last,
  output wire        cell_ready,
  output reg         scrub_wr_q,
  output reg  [LOC_W-1:0] scrub_loc_q,
  output reg  [1:0]  scrub_mask_q,
  output reg         cfg_error_q,
  // JTAG pins, sampled on aclk.
  input  wire        tck,
  input  wire        tdi,
  input  wire        jtag_shift,
  input  wire        jtag_update,
  input  wire [`CMC_IR_W-1:0] jtag_ir,
  output reg         tdo_q,
  // Status pin and core report.
  output reg         crc_error_q,
  output reg         test_mode_q,
  output reg  [`CMC_RPT_W-1:0] core_report_q,
  // AXI4-Lite slave.
  input  wire [`CMC_ADDR_W-1:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [`CMC_ADDR_W-1:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready
);

  // ---------------------------------------------------------------------------
  // Functions.
  // ---------------------------------------------------------------------------
  // Serial CRC step, msb first, ANSI polynomial.
  function [31:0] crc32_step;
    input [31:0] c;
    input        b;
    begin
      crc32_step = {c[30:0], 1'b0} ^ ((c[31] ^ b) ? `CMC_POLY32 : `CMC_ZERO32);
    end
  endfunction

  function [15:0] crc16_step;
    input [15:0] c;
    input        b;
    begin
      crc16_step = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? `CMC_POLY16 : `CMC_ZERO16);
    end
  endfunction

  // ---------------------------------------------------------------------------
  // Synchronisers for pins from outside the clock domain.
  // ---------------------------------------------------------------------------
  reg [1:0] s_tck_q, s_tdi_q, s_sh_q, s_up_q, s_rq_q;
  reg       tck_d1_q;
  reg [`CMC_IR_W-1:0] ir_m_q, ir_q;

  // Two flops per pin. The instruction word only changes while the scan clock
  // rests, so all its bits have settled well before an edge makes use of them.
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_tck_q  <= 2'b00;
      s_tdi_q  <= 2'b00;
      s_sh_q   <= 2'b00;
      s_up_q   <= 2'b00;
      s_rq_q   <= 2'b11;
      tck_d1_q <= 1'b0;
      ir_m_q   <= {`CMC_IR_W{1'b0}};
      ir_q     <= {`CMC_IR_W{1'b0}};
    end else if (aclk_en) begin
      s_tck_q  <= {s_tck_q[0], tck};
      s_tdi_q  <= {s_tdi_q[0], tdi};
      s_sh_q   <= {s_sh_q[0], jtag_shift};
      s_up_q   <= {s_up_q[0], jtag_update};
      s_rq_q   <= {s_rq_q[0], reconfig_request_n};
      tck_d1_q <= s_tck_q[1];
      ir_m_q   <= jtag_ir;
      ir_q     <= ir_m_q;
    end
  end

  wire tck_rise = s_tck_q[1] & ~tck_d1_q;
  wire tck_fall = ~s_tck_q[1] & tck_d1_q;
  wire reconf   = ~s_rq_q[1];
  wire ckr_rst  = ~aresetn | reconf;

  // ---------------------------------------------------------------------------
  // Frame CRC engine.
  // ---------------------------------------------------------------------------
  // Data bits run through the CRC, then the stored 32-bit reference follows
  // inside the same frame, so a clean frame ends with an all-zero remainder.
  reg [31:0]         crc_q;
  reg [15:0]         crc16_q;
  reg [LOC_W-1:0]    pos_q;
  reg                first_q;
  reg                err_pend_q;
  reg [31:0]         syn_q;
  reg [LOC_W-1:0]    fpos_q;
  reg [`CMC_INS_W-1:0] ins_q;
  reg                scrub_en_q;
  // Search state sits here because the stream stall below depends on it.
  reg [31:0]         e1_q, e1p_q;
  reg [LOC_W-1:0]    k_q;
  reg                srch_q;
  // A single flip matches one walked syndrome, an adjacent pair two of them.
  wire hit_one   = (syn_q == e1_q);
  wire hit_two   = (k_q != {LOC_W{1'b0}}) & (syn_q == (e1_q ^ e1p_q));
  wire srch_done = srch_q & (k_q == fpos_q);
  // The search ends on a match or once bit 0 of the frame has been tried.
  wire srch_end  = srch_q & (hit_one | hit_two | (k_q == fpos_q));

  wire take     = cell_valid & cell_ready & ~cell_skip;
  wire [3:0] ins_type = ins_q[`CMC_INS_TYPE_HI:`CMC_INS_TYPE_LO];
  wire [LOC_W-1:0] ins_loc = ins_q[`CMC_INS_LOC_LO+LOC_W-1:`CMC_INS_LOC_LO];
  wire hit1 = (pos_q == ins_loc);
  wire hit2 = (pos_q == ins_loc + 1'b1) & (ins_type == `CMC_TYPE_DOUBLE);
  wire inj  = first_q & ~cfg_mode & (hit1 | hit2) &
              ((ins_type == `CMC_TYPE_SINGLE) | (ins_type == `CMC_TYPE_DOUBLE));
  wire bit_in = cell_bit ^ inj;
  wire [31:0] crc_nx = crc32_step(crc_q, bit_in);

  // Stall the stream while a fault search is still running.
  assign cell_ready = ~err_pend_q;

  always @(posedge aclk) begin
    if (ckr_rst) begin
      crc_q       <= `CMC_ZERO32;
      crc16_q     <= `CMC_ZERO16;
      pos_q       <= {LOC_W{1'b0}};
      first_q     <= 1'b1;
      err_pend_q  <= 1'b0;
      syn_q       <= `CMC_ZERO32;
      crc_error_q <= 1'b0;
      cfg_error_q <= 1'b0;
    end else if (aclk_en) begin
      if (take & cfg_mode) begin
        // Configuration frames carry a 16-bit check at their tail.
        crc16_q <= cell_last ? `CMC_ZERO16 : crc16_step(crc16_q, cell_bit);
        if (cell_last && crc16_step(crc16_q, cell_bit) != `CMC_ZERO16)
          cfg_error_q <= 1'b1;
      end else if (take) begin
        crc_q <= cell_last ? `CMC_ZERO32 : crc_nx;
        pos_q <= cell_last ? {LOC_W{1'b0}} : pos_q + 1'b1;
        if (cell_last) begin
          first_q     <= 1'b0;
          syn_q       <= crc_nx;
          crc_error_q <= (crc_nx != `CMC_ZERO32);
          err_pend_q  <= (crc_nx != `CMC_ZERO32);
        end
      end else if (err_pend_q && srch_end) begin
        err_pend_q <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Fault location search.
  // ---------------------------------------------------------------------------
  // The search walks the syndrome of a single flip at each position back
  // from the frame end; it costs one cycle per frame bit but needs no table.
  reg [`CMC_RPT_W-1:0] rpt_q;
  reg             rpt_new_q;
  wire [31:0] e1_nx = crc32_step(e1_q, 1'b0);
  // Position that the current walk step stands for; the walk starts at the
  // last frame bit and moves one bit towards the start per cycle.
  wire [LOC_W-1:0] srch_loc = fpos_q - k_q;
  // Unused report bits between the location and the syndrome.
  localparam PAD_W = `CMC_RPT_W - `CMC_SYN_W - `CMC_TYPE_W - LOC_W;

  always @(posedge aclk) begin
    if (ckr_rst) begin
      e1_q      <= `CMC_ZERO32;
      e1p_q     <= `CMC_ZERO32;
      k_q       <= {LOC_W{1'b0}};
      srch_q    <= 1'b0;
      rpt_q     <= {`CMC_RPT_W{1'b0}};
      rpt_new_q <= 1'b0;
      fpos_q    <= {LOC_W{1'b0}};
      scrub_wr_q   <= 1'b0;
      scrub_loc_q  <= {LOC_W{1'b0}};
      scrub_mask_q <= 2'b00;
    end else if (aclk_en) begin
      rpt_new_q  <= 1'b0;
      scrub_wr_q <= 1'b0;
      if (take && !cfg_mode && cell_last && crc_nx != `CMC_ZERO32) begin
        srch_q <= 1'b1;
        fpos_q <= pos_q;
        e1_q   <= crc32_step(`CMC_ZERO32, 1'b1);
        e1p_q  <= `CMC_ZERO32;
        k_q    <= {LOC_W{1'b0}};
        rpt_q  <= {crc_nx, {(PAD_W+LOC_W){1'b0}}, `CMC_TYPE_MULTI};
      end else if (srch_q) begin
        // Syndrome of a flip at distance k from the last frame bit.
        if (hit_one) begin
          rpt_q <= {syn_q, {PAD_W{1'b0}}, srch_loc, `CMC_TYPE_SINGLE};
          srch_q <= 1'b0;
          rpt_new_q <= 1'b1;
          scrub_wr_q   <= scrub_en_q;
          scrub_loc_q  <= srch_loc;
          scrub_mask_q <= `CMC_MASK_ONE;
        end else if (hit_two) begin
          rpt_q <= {syn_q, {PAD_W{1'b0}}, srch_loc, `CMC_TYPE_DOUBLE};
          srch_q <= 1'b0;
          rpt_new_q <= 1'b1;
          scrub_wr_q   <= scrub_en_q;
          scrub_loc_q  <= srch_loc;
          scrub_mask_q <= `CMC_MASK_TWO;
        end else if (srch_done) begin
          srch_q    <= 1'b0; // Unlocated pattern keeps the multi code.
          rpt_new_q <= 1'b1;
        end else begin
          e1p_q <= e1_q;
          e1_q  <= e1_nx;
          k_q   <= k_q + 1'b1;
        end
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Update registers and JTAG scan paths.
  // ---------------------------------------------------------------------------
  reg [`CMC_RPT_W-1:0] jupd_q, jsh_q;
  reg [`CMC_INS_W-1:0] jins_q;
  reg                  up_d1_q;
  reg                  jupd_pend_q;
  wire sel_rpt = (ir_q == `CMC_IR_REPORT);
  wire sel_ins = (ir_q == `CMC_IR_INSERT) & ~cfg_mode;
  wire up_rise = s_up_q[1] & ~up_d1_q;

  always @(posedge aclk) begin
    if (ckr_rst) begin
      jupd_q <= {`CMC_RPT_W{1'b0}};
      core_report_q <= {`CMC_RPT_W{1'b0}};
      jsh_q  <= {`CMC_RPT_W{1'b0}};
      jins_q <= {`CMC_INS_W{1'b0}};
      ins_q  <= {`CMC_INS_W{1'b0}};
      tdo_q  <= 1'b0;
      up_d1_q <= 1'b0;
      jupd_pend_q <= 1'b0;
      test_mode_q <= 1'b0;
    end else if (aclk_en) begin
      up_d1_q <= s_up_q[1];
      // Update copy is held off while the host is shifting the report path, so a capture
      // never sees a half-written report; a report that lands mid-shift is
      // kept pending and copied as soon as the shift is over.
      if (rpt_new_q || jupd_pend_q) begin
        if (sel_rpt && s_sh_q[1]) begin
          jupd_pend_q <= 1'b1;
        end else begin
          jupd_q      <= rpt_q;
          jupd_pend_q <= 1'b0;
        end
      end
      if (rpt_new_q)
        core_report_q <= rpt_q;
      if (sel_rpt && tck_rise)
        jsh_q <= s_sh_q[1] ? {s_tdi_q[1], jsh_q[`CMC_RPT_W-1:1]} : jupd_q;
      if (sel_ins && s_sh_q[1] && tck_rise)
        jins_q <= {s_tdi_q[1], jins_q[`CMC_INS_W-1:1]};
      if (sel_ins && up_rise) begin
        ins_q <= jins_q;
        test_mode_q <= 1'b1;
      end
      // Scan out moves on the falling edge so the host sees a settled bit.
      if (tck_fall)
        tdo_q <= sel_rpt ? jsh_q[0] : sel_ins ? jins_q[0] : 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // AXI4-Lite slave.
  // ---------------------------------------------------------------------------
  // Write address and data are taken together in one cycle; one outstanding
  // write and read at a time keeps the slave free of skid buffers.
  assign s_axi_awready = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
  assign s_axi_wready  = s_axi_awready;
  assign s_axi_arready = ~s_axi_rvalid;

  always @(posedge aclk) begin
    if (!aresetn) begin
      scrub_en_q   <= `CMC_CTRL_RST;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `CMC_RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp  <= `CMC_RESP_OKAY;
      s_axi_rdata  <= `CMC_ZERO32;
    end else if (aclk_en) begin
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (s_axi_awready) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `CMC_RESP_OKAY;
        if (s_axi_awaddr == `CMC_REG_CTRL) begin
          if (s_axi_wstrb[0])
            scrub_en_q <= s_axi_wdata[`CMC_CTRL_SCRUB];
        end else if (s_axi_awaddr != `CMC_REG_STATUS && s_axi_awaddr != `CMC_REG_RPT0 &&
                     s_axi_awaddr != `CMC_REG_RPT1 && s_axi_awaddr != `CMC_REG_RPT2) begin
          s_axi_bresp <= `CMC_RESP_SLVERR;
        end
      end
      if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `CMC_RESP_OKAY;
        // The report spans three words; the top word holds its last three bits.
        case (s_axi_araddr)
          `CMC_REG_CTRL:   s_axi_rdata <= {31'h0, scrub_en_q};
          `CMC_REG_STATUS: s_axi_rdata <= {28'h0, test_mode_q, err_pend_q, cfg_error_q, crc_error_q};
          `CMC_REG_RPT0:   s_axi_rdata <= core_report_q[31:0];
          `CMC_REG_RPT1:   s_axi_rdata <= core_report_q[63:32];
          `CMC_REG_RPT2:   s_axi_rdata <= {29'h0, core_report_q[66:64]};
          default: begin
            s_axi_rdata <= `CMC_ZERO32;
            s_axi_rresp <= `CMC_RESP_SLVERR;
          end
        endcase
      end
    end
  end

endmodule // cmc_checker
`default_nettype wire

// File: inc/cmc_map.vh
`ifndef CMC_MAP_VH
`define CMC_MAP_VH

// ---------------------------------------------------------------------------
// Register offsets (byte addresses on the AXI4-Lite bus).
// ---------------------------------------------------------------------------
`define CMC_REG_CTRL      4'h0
`define CMC_REG_STATUS    4'h4
`define CMC_REG_RPT0      4'h8
`define CMC_REG_RPT1      4'hc
`define CMC_REG_RPT2      5'h10
`define CMC_ADDR_W        5

// ---------------------------------------------------------------------------
// Control fields and reset value.
// ---------------------------------------------------------------------------
`define CMC_CTRL_SCRUB    0
`define CMC_CTRL_RST      1'b0

// ---------------------------------------------------------------------------
// Fault report layout and error type codes.
// ---------------------------------------------------------------------------
`define CMC_RPT_W         67
`define CMC_TYPE_NONE     4'h0
`define CMC_TYPE_SINGLE   4'h1
`define CMC_TYPE_DOUBLE   4'h2
`define CMC_TYPE_MULTI    4'hf
`define CMC_TYPE_W        4
`define CMC_SYN_W         32
`define CMC_MASK_ONE      2'b01
`define CMC_MASK_TWO      2'b11

// ---------------------------------------------------------------------------
// Fault insertion register layout.
// ---------------------------------------------------------------------------
`define CMC_INS_W         47
`define CMC_INS_TYPE_HI   46
`define CMC_INS_TYPE_LO   43
`define CMC_INS_LOC_HI    42
`define CMC_INS_LOC_LO    32

// ---------------------------------------------------------------------------
// JTAG instruction codes and CRC constants.
// ---------------------------------------------------------------------------
`define CMC_IR_W          10
`define CMC_IR_REPORT     10'h017
`define CMC_IR_INSERT     10'h015
`define CMC_POLY32        32'h04c11db7
`define CMC_POLY16        16'h8005
`define CMC_ZERO32        32'h00000000
`define CMC_ONES32        32'hffffffff
`define CMC_ZERO16        16'h0000
`define CMC_RESP_OKAY     2'b00
`define CMC_RESP_SLVERR   2'b10

`endif

// File: bench/cmc_checker_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "cmc_map.vh"
// ---------------------------------------------------------------
// Port checker for the frame integrity block.
// ---------------------------------------------------------------
module cmc_sva (
  // Clock and resets.
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        reconfig_request_n,
  // Stream, status and report.
  input wire logic        cfg_mode,
  input wire logic        cell_valid,
  input wire logic        cell_ready,
  input wire logic        cell_last,
  input wire logic        crc_error_q,
  input wire logic        cfg_error_q,
  input wire logic        test_mode_q,
  input wire logic        scrub_wr_q,
  input wire logic [1:0]  scrub_mask_q,
  input wire logic [66:0] core_report_q,
  input wire logic [9:0]  jtag_ir,
  // Read channel.
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Pin history, since the pin crosses two flops before it clears state.
  logic [3:0] rc_q;
  always_ff @(posedge aclk) rc_q <= aresetn ? {rc_q[2:0], reconfig_request_n} : 4'hf;
  wire rc_hit = ~&rc_q;
  property p_flag_src;
    !$stable(crc_error_q) |-> $past(cell_valid && cell_ready && cell_last) || rc_hit;
  endproperty
  a_flag_src: assert property (p_flag_src) else $error("flag moved off a frame end");
  property p_search;
    $fell(cell_ready) |-> ##[1:200] (cell_ready && core_report_q[3:0] != 4'h0);
  endproperty
  a_search: assert property (p_search) else $error("search gave no report");
  property p_type;
    core_report_q[3:0] inside {4'h0, 4'h1, 4'h2, 4'hf};
  endproperty
  a_type: assert property (p_type) else $error("reserved type code");
  property p_insert;
    $rose(test_mode_q) |-> jtag_ir == `CMC_IR_INSERT && !cfg_mode;
  endproperty
  a_insert: assert property (p_insert) else $error("test mode without insertion");
  property p_reconf;
    !reconfig_request_n [*4] |=> !test_mode_q && !crc_error_q && !cfg_error_q;
  endproperty
  a_reconf: assert property (p_reconf) else $error("reconfig left state");
  property p_cfg_sticky;
    $fell(cfg_error_q) |-> rc_hit;
  endproperty
  a_cfg_sticky: assert property (p_cfg_sticky) else $error("config error cleared");
  property p_scrub;
    scrub_wr_q |-> scrub_mask_q inside {2'b01, 2'b11} ##1 !scrub_wr_q;
  endproperty
  a_scrub: assert property (p_scrub) else $error("bad scrub request");
  property p_rhold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read answer dropped");
  c_err: cover property ($rose(crc_error_q));
  c_ins: cover property ($rose(test_mode_q));
  c_scr: cover property (scrub_wr_q);
endmodule // cmc_sva
bind cmc_checker cmc_sva u_sva (.aclk, .aresetn, .reconfig_request_n, .cfg_mode, .cell_valid, .cell_ready,
  .cell_last, .crc_error_q, .cfg_error_q, .test_mode_q, .scrub_wr_q, .scrub_mask_q, .core_report_q, .jtag_ir,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata);
`default_nettype wire

// File: bench/cmc_jtag_host.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// Test host that drives the scan pins.
// ---------------------------------------------------------------
module cmc_jtag_host (
  // Pacing clock.
  input  wire logic       aclk,
  // Scan pins; the scan clock rests low between scans.
  output var  logic       tck = 1'b0,
  output var  logic       tdi = 1'b0,
  output var  logic       jtag_shift = 1'b0,
  output var  logic       jtag_update = 1'b0,
  output var  logic [9:0] jtag_ir = 10'h000,
  input  wire logic       tdo_q
);
  // Capture, shift n bits lsb first, then update, at 800 ns per scan clock.
  task automatic scan(input logic [9:0] ir, input int n, input logic [66:0] din, output logic [66:0] dout);
    dout = '0;
    jtag_ir <= ir;
    repeat (4) @(posedge aclk);
    tck <= 1'b1;
    repeat (4) @(posedge aclk);
    tck <= 1'b0;
    jtag_shift <= 1'b1;
    for (int i = 0; i < n; i++) begin
      tdi <= din[i];
      repeat (4) @(posedge aclk);
      tck <= 1'b1;
      // Read while the rise is still in the synchroniser, so tdo is settled.
      repeat (2) @(posedge aclk);
      dout[i] = tdo_q;
      repeat (2) @(posedge aclk);
      tck <= 1'b0;
    end
    // A released data line shows the inverse, not a stale copy.
    tdi <= ~din[n-1];
    jtag_shift <= 1'b0;
    repeat (4) @(posedge aclk);
    jtag_update <= 1'b1;
    repeat (4) @(posedge aclk);
    jtag_update <= 1'b0;
    repeat (4) @(posedge aclk);
  endtask
endmodule // cmc_jtag_host
`default_nettype wire

// File: bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "cmc_map.vh"
`define CHK(g, x) begin num_checks++; if ((g) !== (x)) begin failures++; $display("unexpected at %0t: got %0h exp %0h", $time, g, x); end end
// ---------------------------------------------------------------
// Bench top: bus, stream and scan traffic.
// ---------------------------------------------------------------
module tb_top;
  localparam int FB = 16;
  int failures = 0;
  int num_checks = 0;
  logic aclk = 1'b0;
  wire aclk_en = 1'b1;
  wire [3:0] s_axi_wstrb = 4'hf;
  logic aresetn = 1'b0, reconfig_request_n = 1'b1, cfg_mode = 1'b0;
  logic cell_valid = 1'b0, cell_bit = 1'b0, cell_skip = 1'b0, cell_last = 1'b0;
  logic [4:0] s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic tck, tdi, jtag_shift, jtag_update, tdo_q, e;
  logic cell_ready, scrub_wr_q, cfg_error_q, crc_error_q, test_mode_q;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [9:0] jtag_ir;
  logic [1:0] scrub_mask_q, s_axi_bresp, s_axi_rresp, smask, r;
  logic [10:0] scrub_loc_q, sloc;
  logic [66:0] core_report_q, q;

  always #50 aclk = ~aclk;
  cmc_checker #(.FRAME_BITS(FB)) dut (.aclk, .aclk_en, .aresetn, .reconfig_request_n, .cfg_mode, .cell_valid,
    .cell_bit, .cell_skip, .cell_last, .cell_ready, .scrub_wr_q, .scrub_loc_q, .scrub_mask_q, .cfg_error_q, .tck,
    .tdi, .jtag_shift, .jtag_update, .jtag_ir, .tdo_q, .crc_error_q, .test_mode_q, .core_report_q, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
  cmc_jtag_host u_host (.aclk, .tck, .tdi, .jtag_shift, .jtag_update, .jtag_ir, .tdo_q);

  // Keep the last correction request, since it is only a one-cycle pulse.
  always @(posedge aclk) if (scrub_wr_q) {smask, sloc} <= {scrub_mask_q, scrub_loc_q};

  // Bus write; both halves offered together, each released once taken.
  task automatic wr(input logic [4:0] a, input logic [31:0] v, output logic [1:0] rs);
    {s_axi_awaddr, s_axi_wdata} <= {a, v};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  // Bus read; rready comes late so the slave must hold its answer.
  task automatic rd(input logic [4:0] a, output logic [31:0] v, output logic [1:0] rs);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1'b1;
    end while (!(s_axi_rvalid && s_axi_rready));
    {v, rs} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  // One memory cell, held until the block takes it.
  task automatic put(input logic b, input logic sk, input logic l);
    {cell_bit, cell_skip, cell_last, cell_valid} <= {b, sk, l, 1'b1};
    do @(posedge aclk); while (!cell_ready);
  endtask
  // Data with one skipped cell, then the reference remainder msb first.
  task automatic frame(input logic [FB-1:0] flip, input logic cfg);
    logic [31:0] c;
    logic [FB-1:0] dat;
    logic fb;
    int w;
    c = 32'h0;
    dat = 16'hb3c5;
    w = cfg ? 16 : 32;
    cfg_mode <= cfg;
    for (int i = 0; i < FB; i++) begin
      fb = c[w-1] ^ dat[i];
      c = (w == 16) ? {16'h0, c[14:0], 1'b0} : {c[30:0], 1'b0};
      if (fb) c = c ^ (cfg ? {16'h0, `CMC_POLY16} : `CMC_POLY32);
    end
    for (int i = 0; i < FB; i++) begin
      if (i == 12) put(1'b1, 1'b1, 1'b0);
      put(dat[i] ^ flip[i], 1'b0, 1'b0);
    end
    for (int i = w - 1; i >= 0; i--) put(c[i], 1'b0, i == 0);
    cell_valid <= 1'b0;
    repeat (2) @(posedge aclk);
    e = crc_error_q;
    repeat (2) @(posedge aclk);
    while (!cell_ready) @(posedge aclk);
    repeat (3) @(posedge aclk);
  endtask
  // Verdict and end of run.
  task automatic wrap_up;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Main sequence.
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(5'h00, d, r);
    `CHK(d, 32'h0)
    rd(5'h14, d, r);
    `CHK(r, `CMC_RESP_SLVERR)
    wr(5'h14, 32'h1, r);
    `CHK(r, `CMC_RESP_SLVERR)
    wr(5'h00, 32'h1, r);
    rd(5'h00, d, r);
    `CHK(d, 32'h1)
    frame(16'h0, 1'b0);
    `CHK(e, 1'b0)
    frame(16'h0020, 1'b0);
    `CHK(e, 1'b1)
    rd(5'h08, d, r);
    `CHK(d[14:0], {11'd5, 4'h1})
    `CHK(core_report_q[14:0], {11'd5, 4'h1})
    `CHK({smask, sloc}, {2'b01, 11'd5})
    u_host.scan(`CMC_IR_REPORT, 67, 67'h0, q);
    `CHK(q[14:0], {11'd5, 4'h1})
    frame(16'h0180, 1'b0);
    rd(5'h08, d, r);
    `CHK({e, d[14:0]}, {1'b1, 11'd7, 4'h2})
    `CHK({smask, sloc}, {2'b11, 11'd7})
    frame(16'h0421, 1'b0);
    rd(5'h08, d, r);
    `CHK({e, d[3:0]}, {1'b1, 4'hf})
    frame(16'h0, 1'b1);
    `CHK(cfg_error_q, 1'b0)
    frame(16'h0001, 1'b1);
    `CHK(cfg_error_q, 1'b1)
    u_host.scan(`CMC_IR_INSERT, 47, {20'h0, 4'h1, 11'd3, 32'h0}, q);
    `CHK(test_mode_q, 1'b0)
    cfg_mode <= 1'b0;
    u_host.scan(`CMC_IR_INSERT, 47, {20'h0, 4'h1, 11'd3, 32'h0}, q);
    `CHK(test_mode_q, 1'b1)
    reconfig_request_n <= 1'b0;
    repeat (6) @(posedge aclk);
    `CHK({test_mode_q, crc_error_q, cfg_error_q}, 3'b000)
    reconfig_request_n <= 1'b1;
    repeat (6) @(posedge aclk);
    u_host.scan(`CMC_IR_INSERT, 47, {20'h0, 4'h1, 11'd3, 32'h0}, q);
    frame(16'h0, 1'b0);
    rd(5'h08, d, r);
    `CHK({e, d[14:0]}, {1'b1, 11'd3, 4'h1})
    frame(16'h0, 1'b0);
    `CHK(e, 1'b0)
    wrap_up;
  end

  // Watchdog, well beyond the few thousand cycles the sequence needs.
  initial begin
    #4000000;
    failures++;
    wrap_up;
  end
endmodule // tb_top
`default_nettype wire
